// ===== logic/enc_emul_pkg.sv
`default_nettype none
package enc_emul_pkg;
  // ----------------------------------------------------------------
  // Clock and link timing
  // ----------------------------------------------------------------
  localparam int SYS_CLK_MHZ = 250;
  localparam int SSI_TOUT_SHORT_NS = 1300;
  localparam int SSI_TOUT_LONG_NS = 10000;
  localparam logic [11:0] SSI_TOUT_SHORT_CYC =
    12'((SSI_TOUT_SHORT_NS * SYS_CLK_MHZ + 999) / 1000);
  localparam logic [11:0] SSI_TOUT_LONG_CYC =
    12'((SSI_TOUT_LONG_NS * SYS_CLK_MHZ + 999) / 1000);
  localparam int SSI_PERIOD_NS = 600;
  localparam logic [11:0] SSI_HALF_CYC = 12'((SSI_PERIOD_NS * SYS_CLK_MHZ / 1000) / 2);
  localparam int FOLLOW_MAX_KHZ = 1500;
  localparam logic [11:0] FOLLOW_HALF_CYC =
    12'((SYS_CLK_MHZ * 1000 + 2 * FOLLOW_MAX_KHZ - 1) / (2 * FOLLOW_MAX_KHZ));

  // ----------------------------------------------------------------
  // Emulation limits and modes
  // ----------------------------------------------------------------
  localparam logic [19:0] LINES_MIN = 20'h00010;
  localparam logic [19:0] LINES_RES_MAX = 20'h00400;
  localparam logic [19:0] LINES_SINE_MAX = 20'h01000;
  localparam logic [4:0] REV_BITS_MIN = 5'h0c;
  localparam logic [4:0] REV_BITS_MAX = 5'h10;
  localparam logic [4:0] ANGLE_BITS = 5'h10;
  localparam logic [2:0] INTERP_SHIFT_MIN = 3'h2;
  localparam logic [2:0] INTERP_SHIFT_MAX = 3'h7;
  typedef enum logic [2:0] {
    MODE_QUAD_ABS, MODE_QUAD_INTERP, MODE_SERIAL, MODE_FOLLOW_QUAD, MODE_FOLLOW_STEP
  } mode_t;

  // ----------------------------------------------------------------
  // Synchroniser bit positions and reset values
  // ----------------------------------------------------------------
  localparam int SI_SCLK = 0;
  localparam int SI_FA = 1;
  localparam int SI_FB = 2;
  localparam int SI_EA = 3;
  localparam int SI_EB = 4;
  localparam int SI_EZ = 5;
  localparam int HI_QA = 0;
  localparam int HI_QB = 1;
  localparam int HI_IDX = 2;
  localparam int HI_SD = 3;
  localparam logic DEV_SDATA_RST = 1'h1;
  localparam logic DEV_AEN_RST = 1'h1;
  localparam logic HOST_SCLK_RST = 1'h1;
  localparam logic [5:0] HOST_FRAME_BITS_RST = 6'h1c;

  // ----------------------------------------------------------------
  // Host register map
  // ----------------------------------------------------------------
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_FOLLOW = 5'h04;
  localparam logic [4:0] REG_DATA = 5'h08;
  localparam logic [4:0] REG_STATUS = 5'h0c;
  localparam logic [4:0] REG_QCOUNT = 5'h10;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_GRAY_BIT = 1;
  localparam int CTRL_LONG_BIT = 2;
  localparam int CTRL_STEP_BIT = 3;
  localparam int CTRL_BITS_LSB = 8;
  localparam int FOLLOW_GO_BIT = 0;
  localparam int FOLLOW_DIR_BIT = 1;
endpackage
`default_nettype wire

// ===== logic/enc_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface enc_link_if;
  logic quad_a;
  logic quad_b;
  logic index_pulse;
  logic ssi_clk;
  logic ssi_data;
  logic follow_a;
  logic follow_b;
  modport device(output quad_a, output quad_b, output index_pulse, output ssi_data,
    input ssi_clk, input follow_a, input follow_b);
  modport host(input quad_a, input quad_b, input index_pulse, input ssi_data,
    output ssi_clk, output follow_a, output follow_b);
endinterface
`default_nettype wire

// ===== logic/encoder_emulation_follower.sv
// Contract
// - Quadrature pulses derived from absolute shaft position.
// - Channels A and B ninety degrees apart, index.
// - Line count settable within feedback dependent range.
// - Index once per turn at A=B=1, offset.
// - Interpolation multiplies encoder edges, passes index through.
// - Count up for clockwise shaft by default.
// - Serial frame carries at most 32 bits.
// - Revolutions 12 to 16 bits, then 16 angle.
// - Serial word Gray or binary, binary default.
// - Serial timeout 1.3 or 10 microseconds.
// - Follow master quadrature, scaled per turn, analog off.
// - One master output may feed sixteen followers.
// - Master differential pulse rate at most 1.5 MHz.
// - 24 V master rate at most 100 kHz.
// - Sine master signal at most 350 kHz.
// - Step/direction follow, scaled per turn, analog off.
//
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/100ps
`default_nettype none
module encoder_emulation_follower
  import enc_emul_pkg::*;
#(
  parameter int TURN_W = 20
) (
  input wire logic sys_clk,
  input wire logic rst,
  enc_link_if.device link,
  input wire logic [31:0] shaft_pos,
  input wire logic feedback_is_resolver,
  input wire mode_t emulation_mode_select,
  input wire logic [19:0] line_count,
  input wire logic [19:0] index_angle_offset,
  input wire logic [2:0] interp_shift,
  input wire logic count_reverse,
  input wire logic [4:0] revolution_bit_count,
  input wire logic gray_select,
  input wire logic serial_timeout_select,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic enc_z,
  input wire logic [TURN_W-1:0] pulses_per_turn,
  output logic [TURN_W-1:0] follow_pulse_in_turn,
  output logic [15:0] follow_revolutions,
  output logic analog_setpoint_enable
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [5:0] s1;
    logic [5:0] s2;
    logic [5:0] pv;
    logic [21:0] edge_cnt;
    logic [1:0] phase;
    logic [15:0] pend;
    logic qa;
    logic qb;
    logic qidx;
    logic busy;
    logic [31:0] shreg;
    logic [11:0] tout;
    logic sdata;
    logic [TURN_W-1:0] fpos;
    logic [15:0] frev;
    logic aen;
  } dev_st_t;

  dev_st_t s_q;
  dev_st_t s_d;
  logic [31:0] pos;
  logic [19:0] lines;
  logic [21:0] four_l;
  logic [37:0] prod;
  logic [21:0] target;
  logic [21:0] diff;
  logic up;
  logic dn;
  logic [1:0] qin;
  logic [1:0] fin;
  logic [2:0] sh;
  logic [4:0] nrev;
  logic [31:0] frame;
  logic [TURN_W-1:0] ppt;
  logic sclk;
  logic fall;
  logic rise;
  logic [11:0] tlim;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Returns {moved, up}; a change of both bits at once is dropped.
  function automatic logic [1:0] quad_step(input logic [1:0] p, input logic [1:0] c);
    logic [1:0] x;
    x = p ^ c;
    quad_step = {(x == 2'h1) || (x == 2'h2), c[1] ^ p[0]};
  endfunction

  // Raises the line count to the minimum, caps a resolver count, and rounds a sine count above the limit down to a power of two.
  function automatic logic [19:0] clamp_lines(input logic [19:0] n, input logic res);
    logic [19:0] r;
    logic [19:0] p;
    r = (n < LINES_MIN) ? LINES_MIN : n;
    p = 20'h0;
    if (res && (r > LINES_RES_MAX)) begin
      r = LINES_RES_MAX;
    end else if (!res && (r > LINES_SINE_MAX)) begin
      for (int i = 0; i < 20; i++) begin
        if (r[i]) begin
          p = 20'h1 << i;
        end
      end
      r = p;
    end
    clamp_lines = r;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // One process computes every next value so the state stays coherent.
  always_comb begin
    s_d = s_q;
    s_d.s1 = {enc_z, enc_b, enc_a, link.follow_b, link.follow_a, link.ssi_clk};
    s_d.s2 = s_q.s1;
    s_d.pv = s_q.s2;
    pos = count_reverse ? 32'(32'h0 - shaft_pos) : shaft_pos;
    lines = clamp_lines(line_count, feedback_is_resolver);
    four_l = {lines, 2'h0};
    prod = pos[15:0] * four_l;
    target = prod[37:16];
    diff = (target >= s_q.edge_cnt) ? (target - s_q.edge_cnt)
                                    : (target + four_l - s_q.edge_cnt);
    up = 1'h0;
    dn = 1'h0;
    qin = quad_step({s_q.pv[SI_EA], s_q.pv[SI_EB]}, {s_q.s2[SI_EA], s_q.s2[SI_EB]});
    sh = (interp_shift < INTERP_SHIFT_MIN) ? INTERP_SHIFT_MIN :
         (interp_shift > INTERP_SHIFT_MAX) ? INTERP_SHIFT_MAX : interp_shift;
    ppt = (pulses_per_turn == '0) ? TURN_W'(1) : pulses_per_turn;
    if (emulation_mode_select == MODE_FOLLOW_QUAD) begin
      fin = quad_step({s_q.pv[SI_FA], s_q.pv[SI_FB]}, {s_q.s2[SI_FA], s_q.s2[SI_FB]});
    end else begin
      fin = {~s_q.pv[SI_FA] & s_q.s2[SI_FA], s_q.s2[SI_FB]};
    end
    s_d.aen = 1'h1;

    // The emulated edge walks at most one step a clock toward the target,
    // so A and B never skip a state even when the shaft jumps.
    unique case (emulation_mode_select)
      MODE_QUAD_ABS: begin
        up = (diff != 22'h0) && (diff < {1'h0, lines, 1'h0});
        dn = (diff != 22'h0) && !up;
        if (up) begin
          s_d.edge_cnt = (s_q.edge_cnt + 22'h1 == four_l) ? 22'h0 : s_q.edge_cnt + 22'h1;
        end
        if (dn) begin
          s_d.edge_cnt = (s_q.edge_cnt == 22'h0) ? four_l - 22'h1 : s_q.edge_cnt - 22'h1;
        end
        s_d.phase = s_d.edge_cnt[1:0];
        s_d.qidx = (s_d.edge_cnt == {index_angle_offset, 2'h2});
      end
      MODE_QUAD_INTERP: begin
        if (s_q.pend != 16'h0) begin
          s_d.phase = s_q.pend[15] ? s_q.phase - 2'h1 : s_q.phase + 2'h1;
          s_d.pend = s_q.pend[15] ? s_q.pend + 16'h1 : s_q.pend - 16'h1;
        end
        if (qin[1]) begin
          s_d.pend = (qin[0] ^ count_reverse) ? s_d.pend + (16'h1 << sh)
                                              : s_d.pend - (16'h1 << sh);
        end
        s_d.qidx = s_q.s2[SI_EZ];
      end
      MODE_SERIAL: begin
      end
      MODE_FOLLOW_QUAD, MODE_FOLLOW_STEP: begin
        s_d.aen = 1'h0;
        if (fin[1] && fin[0]) begin
          if (s_q.fpos + TURN_W'(1) >= ppt) begin
            s_d.fpos = '0;
            s_d.frev = s_q.frev + 16'h1;
          end else begin
            s_d.fpos = s_q.fpos + TURN_W'(1);
          end
        end else if (fin[1]) begin
          if (s_q.fpos == '0) begin
            s_d.fpos = ppt - TURN_W'(1);
            s_d.frev = s_q.frev - 16'h1;
          end else begin
            s_d.fpos = s_q.fpos - TURN_W'(1);
          end
        end
      end
      default: begin
      end
    endcase
    s_d.qa = s_d.phase[0] ^ s_d.phase[1];
    s_d.qb = s_d.phase[1];

    // Serial frame: revolutions on top, angle below, zeros after the end.
    nrev = (revolution_bit_count < REV_BITS_MIN) ? REV_BITS_MIN :
           (revolution_bit_count > REV_BITS_MAX) ? REV_BITS_MAX : revolution_bit_count;
    frame = pos << (ANGLE_BITS - nrev);
    if (gray_select) begin
      frame = (frame ^ (frame >> 1)) & (32'hffffffff << (ANGLE_BITS - nrev));
    end
    sclk = s_q.s2[SI_SCLK];
    fall = s_q.pv[SI_SCLK] & ~sclk;
    rise = ~s_q.pv[SI_SCLK] & sclk;
    tlim = serial_timeout_select ? SSI_TOUT_LONG_CYC : SSI_TOUT_SHORT_CYC;

    // The timeout restarts on every clock edge, so a slow reader only
    // has to keep each half period below it.
    if (!s_q.busy) begin
      s_d.sdata = 1'h1;
      if (fall && (emulation_mode_select == MODE_SERIAL)) begin
        s_d.busy = 1'h1;
        s_d.shreg = frame;
        s_d.sdata = 1'h0;
        s_d.tout = tlim;
      end
    end else begin
      if (fall || rise) begin
        s_d.tout = tlim;
      end else if (s_q.tout != 12'h0) begin
        s_d.tout = s_q.tout - 12'h1;
      end
      if (rise) begin
        s_d.sdata = s_q.shreg[31];
        s_d.shreg = {s_q.shreg[30:0], 1'h0};
      end
      if ((s_q.tout == 12'h0) && sclk) begin
        s_d.busy = 1'h0;
        s_d.sdata = 1'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Plain synchronous reset; idle serial line and analog path come up high.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_q <= '{sdata: DEV_SDATA_RST, aen: DEV_AEN_RST, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs are plain flop copies; followers on one master only listen.
  assign link.quad_a = s_q.qa;
  assign link.quad_b = s_q.qb;
  assign link.index_pulse = s_q.qidx;
  assign link.ssi_data = s_q.sdata;
  assign follow_pulse_in_turn = s_q.fpos;
  assign follow_revolutions = s_q.frev;
  assign analog_setpoint_enable = s_q.aen;

endmodule
`default_nettype wire

// ===== logic/encoder_host.sv
`timescale 1ns/100ps
`default_nettype none
module encoder_host
  import enc_emul_pkg::*;
#(
  parameter int DEPTH = 2
) (
  input wire logic sys_clk,
  input wire logic rst,
  enc_link_if.host link,
  input wire logic [4:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {H_IDLE, H_CLOCK, H_WAIT} hst_t;
  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] pv;
    logic gray;
    logic lng;
    logic stepm;
    logic [5:0] fbits;
    hst_t st;
    logic [11:0] div;
    logic [5:0] bcnt;
    logic sclk;
    logic [31:0] rx;
    logic [DEPTH-1:0][31:0] mem;
    logic wp;
    logic rp;
    logic [1:0] cnt;
    logic [31:0] qcount;
    logic idx_seen;
    logic fa;
    logic fb;
    logic [1:0] fph;
    logic [1:0] fseq;
    logic [11:0] fcnt;
    logic [31:0] rdata;
  } host_st_t;

  host_st_t h_q;
  host_st_t h_d;
  logic [1:0] qs;
  logic wr_ctrl;
  logic wr_follow;
  logic push;
  logic pop;
  logic fbusy;
  logic [11:0] tlim;

  function automatic logic [1:0] quad_step(input logic [1:0] p, input logic [1:0] c);
    logic [1:0] x;
    x = p ^ c;
    quad_step = {(x == 2'h1) || (x == 2'h2), c[1] ^ p[0]};
  endfunction

  function automatic logic [31:0] gray2bin(input logic [31:0] g);
    logic [31:0] b;
    b = g;
    for (int i = 30; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    gray2bin = b;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    h_d = h_q;
    h_d.s1 = {link.ssi_data, link.index_pulse, link.quad_b, link.quad_a};
    h_d.s2 = h_q.s1;
    h_d.pv = h_q.s2;
    qs = quad_step({h_q.pv[HI_QA], h_q.pv[HI_QB]}, {h_q.s2[HI_QA], h_q.s2[HI_QB]});
    if (qs[1]) begin
      h_d.qcount = qs[0] ? h_q.qcount + 32'h1 : h_q.qcount - 32'h1;
    end
    wr_ctrl = reg_write && (reg_addr == REG_CTRL);
    wr_follow = reg_write && (reg_addr == REG_FOLLOW);
    pop = reg_read && (reg_addr == REG_DATA) && (h_q.cnt != 2'h0);
    push = 1'h0;
    fbusy = (h_q.fcnt != 12'h0) || (h_q.fseq != 2'h0);
    tlim = h_q.lng ? SSI_TOUT_LONG_CYC : SSI_TOUT_SHORT_CYC;

    // Read data stands one cycle after the strobe; unmapped reads give zero.
    h_d.rdata = 32'h0;
    if (reg_read) begin
      case (reg_addr)
        REG_CTRL: h_d.rdata = 32'({h_q.fbits, 4'h0, h_q.stepm, h_q.lng, h_q.gray, 1'h0});
        REG_DATA: h_d.rdata = (h_q.cnt != 2'h0) ? h_q.mem[h_q.rp] : 32'h0;
        REG_STATUS: h_d.rdata = 32'({h_q.idx_seen, fbusy, h_q.cnt, h_q.st != H_IDLE});
        REG_QCOUNT: h_d.rdata = h_q.qcount;
        default: h_d.rdata = 32'h0;
      endcase
    end
    // Reading status clears the index flag, but a new index still sets it.
    if (reg_read && (reg_addr == REG_STATUS)) begin
      h_d.idx_seen = 1'h0;
    end
    if (h_q.s2[HI_IDX]) begin
      h_d.idx_seen = 1'h1;
    end

    if (wr_ctrl) begin
      h_d.gray = reg_wdata[CTRL_GRAY_BIT];
      h_d.lng = reg_wdata[CTRL_LONG_BIT];
      h_d.stepm = reg_wdata[CTRL_STEP_BIT];
      h_d.fbits = reg_wdata[CTRL_BITS_LSB+5:CTRL_BITS_LSB];
    end

    // Serial reader; a start is refused while busy or the buffer is full.
    unique case (h_q.st)
      H_IDLE: begin
        if (wr_ctrl && reg_wdata[CTRL_START_BIT] && (h_q.cnt != 2'(DEPTH))) begin
          h_d.st = H_CLOCK;
          h_d.div = SSI_HALF_CYC;
          h_d.bcnt = 6'h0;
          h_d.rx = 32'h0;
        end
      end
      H_CLOCK: begin
        if (h_q.div != 12'h1) begin
          h_d.div = h_q.div - 12'h1;
        end else begin
          h_d.div = SSI_HALF_CYC;
          h_d.sclk = ~h_q.sclk;
          if (h_q.sclk) begin
            h_d.bcnt = h_q.bcnt + 6'h1;
            if (h_q.bcnt != 6'h0) begin
              h_d.rx = {h_q.rx[30:0], h_q.s2[HI_SD]};
            end
          end else if (h_q.bcnt == h_q.fbits + 6'h1) begin
            h_d.st = H_WAIT;
            h_d.div = tlim + SSI_HALF_CYC;
          end
        end
      end
      H_WAIT: begin
        h_d.div = h_q.div - 12'h1;
        if (h_q.div == 12'h1) begin
          push = 1'h1;
          h_d.st = H_IDLE;
        end
      end
      default: begin
        h_d.st = H_IDLE;
      end
    endcase
    if (push) begin
      h_d.mem[h_q.wp] = h_q.gray ? gray2bin(h_q.rx) : h_q.rx;
      h_d.wp = ~h_q.wp;
    end
    if (pop) begin
      h_d.rp = ~h_q.rp;
    end
    h_d.cnt = h_q.cnt + 2'(push) - 2'(pop);

    // Follow pulses: each edge is held at least half a period at the limit.
    if (h_q.fcnt != 12'h0) begin
      h_d.fcnt = h_q.fcnt - 12'h1;
    end else if (h_q.fseq == 2'h2) begin
      h_d.fa = 1'h1;
      h_d.fseq = 2'h1;
      h_d.fcnt = FOLLOW_HALF_CYC;
    end else if (h_q.fseq == 2'h1) begin
      h_d.fa = 1'h0;
      h_d.fseq = 2'h0;
      h_d.fcnt = FOLLOW_HALF_CYC;
    end
    if (wr_follow && reg_wdata[FOLLOW_GO_BIT] && !fbusy) begin
      h_d.fcnt = FOLLOW_HALF_CYC;
      if (h_q.stepm) begin
        h_d.fb = reg_wdata[FOLLOW_DIR_BIT];
        h_d.fseq = 2'h2;
      end else begin
        h_d.fph = reg_wdata[FOLLOW_DIR_BIT] ? h_q.fph + 2'h1 : h_q.fph - 2'h1;
      end
    end
    if (!h_q.stepm) begin
      h_d.fa = h_d.fph[0] ^ h_d.fph[1];
      h_d.fb = h_d.fph[1];
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      h_q <= '{sclk: HOST_SCLK_RST, fbits: HOST_FRAME_BITS_RST, st: H_IDLE, default: '0};
    end else begin
      h_q <= h_d;
    end
  end

  assign link.ssi_clk = h_q.sclk;
  assign link.follow_a = h_q.fa;
  assign link.follow_b = h_q.fb;
  assign reg_rdata = h_q.rdata;

endmodule
`default_nettype wire

// ===== verification/enc_link_checker.sv
`timescale 1ns/100ps
`default_nettype none
module enc_link_checker
  import enc_emul_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic quad_a,
  input wire logic quad_b,
  input wire logic index_pulse,
  input wire logic ssi_clk,
  input wire logic ssi_data,
  input wire logic follow_a,
  input wire logic follow_b
);
  // ----------------------------------------
  // Idle counters
  // ----------------------------------------
  logic [11:0] ci_q;
  logic [11:0] fi_q;
  // Cycles since a pin last moved; they saturate so that a long pause never looks short.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ci_q <= 12'h000;
      fi_q <= 12'hfff;
    end else begin
      ci_q <= $changed(ssi_clk) ? 12'h000 : ci_q + 12'(ci_q != 12'hfff);
      fi_q <= ($changed(follow_a) || $changed(follow_b)) ? 12'h000 : fi_q + 12'(fi_q != 12'hfff);
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Windows are a few cycles wide because the synchronisers may shift an edge by one.
  a_quad_one_step: assert property (!($changed(quad_a) && $changed(quad_b)))
    else $error("quad channels moved together");
  a_index_at_high: assert property (index_pulse |-> quad_a && quad_b)
    else $error("index outside A and B high");
  a_frame_latch: assert property ($fell(ssi_clk) && ci_q > 12'h12c |-> ##[1:6] !ssi_data)
    else $error("data did not drop at frame start");
  a_clk_half: assert property ($changed(ssi_clk) |-> ci_q inside {[12'h048:12'h04c]} || ci_q > 12'h12c)
    else $error("serial clock half period wrong");
  a_data_moves: assert property ($changed(ssi_data) |-> ci_q <= 12'h008 ||
    ci_q inside {[12'h13e:12'h14c]} || ci_q inside {[12'h9ba:12'h9ce]})
    else $error("serial data moved at a wrong time");
  a_data_idle: assert property (ci_q == 12'ha28 && ssi_clk |-> ssi_data)
    else $error("serial data not idle after timeout");
  a_follow_gray: assert property (!($changed(follow_a) && $changed(follow_b)))
    else $error("follower pins moved together");
  a_follow_rate: assert property ($changed(follow_a) || $changed(follow_b) |-> fi_q >= FOLLOW_HALF_CYC - 12'h004)
    else $error("follower pulse rate too high");
  a_reset_idle: assert property (disable iff (1'b0) rst |=> !quad_a && !quad_b && !index_pulse &&
    ssi_data && ssi_clk && !follow_a && !follow_b)
    else $error("link not idle after reset");
  c_frame: cover property ($fell(ssi_clk) && ci_q > 12'h12c);
  c_index: cover property (index_pulse);
  c_step: cover property ($rose(follow_a));
endmodule
`default_nettype wire

// ===== verification/tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
  $display("CHECK FAILED %s exp %0h seen %0h", nm, e, g); end end
module tb;
  import enc_emul_pkg::*;
  logic sys_clk = 1'h0;
  logic rst = 1'h1;
  logic [31:0] shaft_pos = 32'h0;
  logic res_fb = 1'h1;
  mode_t mode = MODE_QUAD_ABS;
  logic [19:0] lines = 20'h10;
  logic [2:0] shift = 3'h2;
  logic [4:0] rbits = 5'h0c;
  logic dgray = 1'h0;
  logic tlong = 1'h0;
  logic rev = 1'h0;
  logic [19:0] idx_off = 20'h0;
  logic enc_a = 1'h0;
  logic enc_b = 1'h0;
  logic [19:0] ppt = 20'h3;
  logic [19:0] f_pos;
  logic [15:0] f_rev;
  logic aen;
  logic [4:0] addr = 5'h0;
  logic [31:0] wdata = 32'h0;
  logic wr_s = 1'h0;
  logic rd_s = 1'h0;
  logic [31:0] rdata;
  logic [31:0] w;
  logic [31:0] v;
  logic [31:0] exp_q[$];
  int n_errors = 0;
  int checks_done = 0;
  int qc = 0;
  int ph = 0;
  int fp = 0;
  int fr = 0;
  enc_link_if link ();
  encoder_emulation_follower encoder_emulation_follower_inst (.sys_clk(sys_clk), .rst(rst),
    .link(link.device), .shaft_pos(shaft_pos), .feedback_is_resolver(res_fb),
    .emulation_mode_select(mode), .line_count(lines), .index_angle_offset(idx_off),
    .interp_shift(shift), .count_reverse(rev), .revolution_bit_count(rbits),
    .gray_select(dgray), .serial_timeout_select(tlong), .enc_a(enc_a), .enc_b(enc_b),
    .enc_z(1'h0), .pulses_per_turn(ppt), .follow_pulse_in_turn(f_pos),
    .follow_revolutions(f_rev), .analog_setpoint_enable(aen));
  encoder_host encoder_host_inst (.sys_clk(sys_clk), .rst(rst), .link(link.host),
    .reg_addr(addr), .reg_wdata(wdata), .reg_write(wr_s), .reg_read(rd_s), .reg_rdata(rdata));
  enc_link_checker enc_link_checker_inst (.sys_clk(sys_clk), .rst(rst), .quad_a(link.quad_a),
    .quad_b(link.quad_b), .index_pulse(link.index_pulse), .ssi_clk(link.ssi_clk),
    .ssi_data(link.ssi_data), .follow_a(link.follow_a), .follow_b(link.follow_b));
  // The system clock runs free at 250 MHz.
  always #2 sys_clk = ~sys_clk;
  // ----------------------------------------
  // Bus and pin tasks
  // ----------------------------------------
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'h1;
    @(posedge sys_clk);
    wr_s <= 1'h0;
  endtask
  // Read data stand only in the cycle after the strobe, so they are taken mid-cycle.
  task automatic rd(input logic [4:0] a);
    @(posedge sys_clk);
    addr <= a;
    rd_s <= 1'h1;
    @(posedge sys_clk);
    rd_s <= 1'h0;
    @(negedge sys_clk);
    w = rdata;
    @(posedge sys_clk);
  endtask
  task automatic poll(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    int i;
    rd(a);
    for (i = 0; i < 4000 && (w & m) !== e; i++) rd(a);
    if ((w & m) !== e) begin
      n_errors++;
      $display("CHECK FAILED wait %0h exp %0h seen %0h", a, e, w & m);
      wrap_up();
    end
  endtask
  task automatic enc_step(input int d);
    ph = (ph + d) & 3;
    enc_a <= (ph == 1 || ph == 2);
    enc_b <= (ph >= 2);
    repeat (180) @(posedge sys_clk);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Above the sine limit a count is rounded down to a power of two.
  function automatic int clamp_l(input logic r, input int l);
    int p;
    p = 4096;
    if (l < 16) return 16;
    if (r) return (l > 1024) ? 1024 : l;
    if (l <= 4096) return l;
    while (p * 2 <= l) p = p * 2;
    return p;
  endfunction
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int lc[4];
    logic [15:0] ang;
    logic d;
    lc = '{8, 300, 2000, 5000};
    w = $urandom(29);
    repeat (10) @(posedge sys_clk);
    rst <= 1'h0;
    rd(5'h14);
    `CHK("unmapped", 32'h0, w)
    `CHK("analog on", 1'h1, aen)
    // Out-of-range counts are clamped; angles stay small so moves never cross a turn.
    for (int i = 0; i < 4; i++) begin
      ang = 16'h0c00 | 16'($urandom & 32'h3ff);
      res_fb <= !i[0];
      lines <= 20'(lc[i]);
      idx_off <= 20'(5 * i);
      shaft_pos <= {16'h0, ang};
      qc = (int'(ang) * 4 * clamp_l(!i[0], lc[i])) >>> 16;
      poll(REG_QCOUNT, 32'hffffffff, 32'(qc));
      `CHK("edges", 32'(qc), w)
      if (i < 2) begin
        rd(REG_STATUS);
        `CHK("index", 1'h1, w[4])
      end
    end
    $display("quadrature test done");
    // The fourth input step is a double transition and must add nothing.
    mode <= MODE_QUAD_INTERP;
    for (int i = 0; i < 2; i++) begin
      shift <= i ? 3'h7 : 3'h1;
      rev <= (i == 1);
      for (int k = 0; k < 6; k++) enc_step(k == 3 ? 2 : 1);
      qc += 5 * (i ? -128 : 4);
      poll(REG_QCOUNT, 32'hffffffff, 32'(qc));
      `CHK("interp", 32'(qc), w)
    end
    $display("interpolation test done");
    rev <= 1'h0;
    mode <= MODE_SERIAL;
    for (int i = 0; i < 3; i++) begin
      rbits <= 5'(12 + 2 * i);
      dgray <= (i != 0);
      tlong <= (i == 1);
      shaft_pos <= $urandom;
      @(posedge sys_clk);
      v = ((shaft_pos >> 16) & ((32'h1 << (12 + 2 * i)) - 32'h1)) << 16 | {16'h0, shaft_pos[15:0]};
      if (i == 1) v = v ^ (v >> 1);
      exp_q.push_back(v);
      wr(REG_CTRL, 32'((28 + 2 * i) << 8) | 32'((i == 1) << 2) | 32'((i == 2) << 1) | 32'h1);
      poll(REG_STATUS, 32'h7, 32'h2);
      rd(REG_DATA);
      v = exp_q.pop_front();
      `CHK("frame", v, w)
    end
    // Two frames fill the buffer; the third start must be refused.
    for (int j = 0; j < 3; j++) begin
      shaft_pos <= $urandom;
      @(posedge sys_clk);
      if (j < 2) exp_q.push_back(shaft_pos);
      wr(REG_CTRL, 32'h00002003);
      if (j < 2) poll(REG_STATUS, 32'h7, 32'(2 * j + 2));
    end
    repeat (400) @(posedge sys_clk);
    rd(REG_STATUS);
    `CHK("full", 32'h4, w & 32'h7)
    for (int j = 0; j < 3; j++) begin
      rd(REG_DATA);
      v = (j < 2) ? exp_q.pop_front() : 32'h0;
      `CHK("buffered", v, w)
    end
    $display("serial test done");
    // Three pulses per turn make the position wrap upward; step directions are random, so a downward wrap may not occur.
    for (int m = 0; m < 2; m++) begin
      mode <= m ? MODE_FOLLOW_STEP : MODE_FOLLOW_QUAD;
      wr(REG_CTRL, 32'h00001c00 | 32'(m << 3));
      `CHK("analog off", 1'h0, aen)
      for (int k = 0; k < 6; k++) begin
        d = m ? 1'($urandom) : (k < 5);
        if (m) repeat (2500) @(posedge sys_clk);
        wr(REG_FOLLOW, {30'h0, d, 1'h1});
        fp = d ? fp + 1 : fp - 1;
        if (fp == 3) fr++;
        if (fp < 0) fr--;
        fp = (fp + 3) % 3;
        poll(REG_STATUS, 32'h8, 32'h0);
        `CHK("follow pos", 20'(fp), f_pos)
        `CHK("follow turns", 16'(fr), f_rev)
      end
    end
    mode <= MODE_QUAD_ABS;
    rd(REG_STATUS);
    `CHK("analog back", 1'h1, aen)
    $display("follower test done");
    wrap_up();
  end
endmodule
`default_nettype wire
